// [src/cbbse_params.svh]
// offsets, field positions, reset values and step sizes of the bit/branch/control unit
`ifndef CBBSE_PARAMS_SVH
`define CBBSE_PARAMS_SVH
// ====================================================================
// register byte offsets
`define CBBSE_OFF_INSTR   6'h00
`define CBBSE_OFF_PC      6'h04
`define CBBSE_OFF_CTRL    6'h08
`define CBBSE_OFF_OPND    6'h0C
`define CBBSE_OFF_SRC     6'h10
`define CBBSE_OFF_DST     6'h14
`define CBBSE_OFF_COUNT   6'h18
`define CBBSE_OFF_STATUS  6'h1C
`define CBBSE_OFF_MADDR   6'h20
`define CBBSE_OFF_MDATA   6'h24
`define CBBSE_OFF_RET     6'h28
// ====================================================================
// condition register bit positions
`define CBBSE_CCR_C 0
`define CBBSE_CCR_V 1
`define CBBSE_CCR_Z 2
`define CBBSE_CCR_N 3
// status bit positions
`define CBBSE_ST_BUSY  0
`define CBBSE_ST_SLEEP 1
`define CBBSE_ST_TAKEN 2
`define CBBSE_ST_EXC   3
// ====================================================================
// bit instruction sub-codes
`define CBBSE_BIT_XOR  4'h0
`define CBBSE_BIT_IXOR 4'h1
`define CBBSE_BIT_LD   4'h2
`define CBBSE_BIT_ILD  4'h3
`define CBBSE_BIT_ST   4'h4
`define CBBSE_BIT_IST  4'h5
// ====================================================================
// reset values and steps
`define CBBSE_RST_PC    16'h0000
`define CBBSE_RST_CCR   8'h80
`define CBBSE_RST_EXR   8'h07
`define CBBSE_UNIT_STEP 16'h0002
`define CBBSE_EXT_STEP  16'h0004
`define CBBSE_TRAP_BASE 16'h0010
`endif

// [src/cbbse_pkg.sv]
// types of the bit/branch/control execution unit
package cbbse_pkg;
  // ====================================================================
  // operation field, first four bits of the leading unit
  typedef enum logic [3:0] {
    OP_NOP, OP_BIT, OP_BCC, OP_JMP, OP_BSR, OP_JSR, OP_RTS, OP_TRAP,
    OP_RTE, OP_SLEEP, OP_LDC, OP_STC, OP_CONTROL_AND_IMM, OP_ORC, OP_CONTROL_XOR_IMM, OP_COPY
  } cbbse_op_e;
  typedef enum logic {ST_IDLE, ST_COPY} cbbse_state_e;
  // one instruction: extension unit above the leading unit
  typedef struct packed {
    logic [15:0] ext;
    cbbse_op_e op;
    logic [3:0] op2;
    logic [7:0] imm8;
  } cbbse_instr_s;
endpackage

// [src/cbbse_exec.sv]
// bit-to-carry, branch, system control and block copy execution unit
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "cbbse_params.svh"
module cbbse_exec #(
  parameter int MEM_AW = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic powerDown
);
  // ====================================================================
  // state
  cbbse_pkg::cbbse_state_e state, next_state;
  logic [15:0] pc, next_pc;
  logic [7:0] condition_register, next_ccr;
  logic [7:0] extended_register, next_exr;
  logic [7:0] opnd, next_opnd;
  logic [15:0] srcPtr, next_srcPtr;
  logic [15:0] dstPtr, next_dstPtr;
  logic [15:0] count, next_count;
  logic [15:0] retAddr, next_retAddr;
  logic [15:0] excPc, next_excPc;
  logic [7:0] excCcr, next_excCcr;
  logic [15:0] memAddr, next_memAddr;
  logic sleepMode, next_sleepMode;
  logic taken, next_taken;
  logic inExc, next_inExc;
  logic copyWord, next_copyWord;
  logic memWe0, memWe1;
  logic [MEM_AW-1:0] memA0;
  logic [7:0] memD0;
  logic [7:0] mem [0:(1<<MEM_AW)-1];

  // merge written bytes over the current word
  function automatic logic [31:0] cbbse_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // branch condition evaluation over the condition register
  function automatic logic cbbse_cond(input logic [7:0] cc, input logic [3:0] code);
    logic c, z, v, n;
    logic r;
    c = cc[`CBBSE_CCR_C];
    z = cc[`CBBSE_CCR_Z];
    v = cc[`CBBSE_CCR_V];
    n = cc[`CBBSE_CCR_N];
    unique case (code)
      4'h0: r = 1'b1;
      4'h1: r = 1'b0;
      4'h2: r = !(c | z);
      4'h3: r = c | z;
      4'h4: r = !c;
      4'h5: r = c;
      4'h6: r = !z;
      4'h7: r = z;
      4'h8: r = !v;
      4'h9: r = v;
      4'hA: r = !n;
      4'hB: r = n;
      4'hC: r = !(n ^ v);
      4'hD: r = n ^ v;
      4'hE: r = !(z | (n ^ v));
      4'hF: r = z | (n ^ v);
    endcase
    return r;
  endfunction

  // ====================================================================
  // decode: the instruction word splits into its fields
  // field split
  cbbse_pkg::cbbse_instr_s ins;
  assign ins = cbbse_pkg::cbbse_instr_s'(avs_writedata);
  wire acc = !avs_waitrequest && (avs_read || avs_write);
  wire wrAcc = acc && avs_write;
  wire doInstr = wrAcc && (avs_address == `CBBSE_OFF_INSTR) && !sleepMode;
  wire [2:0] bitNo = ins.imm8[2:0];
  wire bitMem = ins.imm8[3];
  wire [MEM_AW-1:0] extAddr = ins.ext[MEM_AW-1:0];
  wire [MEM_AW-1:0] extAddr1 = extAddr + 1'b1;
  wire [7:0] opByte = bitMem ? mem[extAddr] : opnd;
  wire bitVal = opByte[bitNo];
  wire carry = condition_register[`CBBSE_CCR_C];
  wire isLdcMem = (ins.op == cbbse_pkg::OP_LDC) && (ins.op2[2:1] == 2'b10);
  wire isStcMem = (ins.op == cbbse_pkg::OP_STC) && ins.op2[1];
  wire isBitMem = (ins.op == cbbse_pkg::OP_BIT) && bitMem;
  wire usesExt = isLdcMem || isStcMem || isBitMem;
  wire [15:0] step = usesExt ? `CBBSE_EXT_STEP : `CBBSE_UNIT_STEP;
  wire [15:0] seqPc = pc + step;
  wire [15:0] bccTarget = pc + `CBBSE_UNIT_STEP + {{8{ins.imm8[7]}}, ins.imm8};
  wire condOk = cbbse_cond(condition_register, ins.op2);
  wire ctlSel = ins.op2[0];
  wire [7:0] ctlReg = ctlSel ? extended_register : condition_register;
  wire [7:0] ldcSrc = (ins.op2[2:1] == 2'b00) ? ins.imm8 :
                      (ins.op2[2:1] == 2'b01) ? opnd : mem[extAddr];
  wire [15:0] cntSel = copyWord ? count : {8'h00, count[7:0]};
  wire [15:0] cntIns = ins.op2[0] ? count : {8'h00, count[7:0]};
  wire [15:0] cntDec = copyWord ? count - 16'h0001 : {count[15:8], count[7:0] - 8'h01};

  // bit value for the store forms, other bits of the byte kept
  wire storeBit = (ins.op2 == `CBBSE_BIT_IST) ? !carry : carry;
  wire [7:0] storedByte = (opByte & ~(8'h01 << bitNo)) | ({7'h00, storeBit} << bitNo);

  // read-back of the addressed register
  wire [31:0] statusWord = {28'h0000_000, inExc, taken, sleepMode, (state == cbbse_pkg::ST_COPY)};
  wire [31:0] curWord =
    (avs_address == `CBBSE_OFF_PC) ? {16'h0000, pc} :
    (avs_address == `CBBSE_OFF_CTRL) ? {16'h0000, extended_register, condition_register} :
    (avs_address == `CBBSE_OFF_OPND) ? {24'h0000_00, opnd} :
    (avs_address == `CBBSE_OFF_SRC) ? {16'h0000, srcPtr} :
    (avs_address == `CBBSE_OFF_DST) ? {16'h0000, dstPtr} :
    (avs_address == `CBBSE_OFF_COUNT) ? {16'h0000, count} :
    (avs_address == `CBBSE_OFF_STATUS) ? statusWord :
    (avs_address == `CBBSE_OFF_MADDR) ? {16'h0000, memAddr} :
    (avs_address == `CBBSE_OFF_MDATA) ? {24'h0000_00, mem[memAddr[MEM_AW-1:0]]} :
    (avs_address == `CBBSE_OFF_RET) ? {16'h0000, retAddr} : 32'h0000_0000;
  wire [31:0] wrWord = cbbse_merge(curWord, avs_writedata, avs_byteenable);

  // ====================================================================
  // next state: block copy, instruction execution, register writes
  always_comb begin
    next_state = state;
    next_pc = pc;
    next_ccr = condition_register;
    next_exr = extended_register;
    next_opnd = opnd;
    next_srcPtr = srcPtr;
    next_dstPtr = dstPtr;
    next_count = count;
    next_retAddr = retAddr;
    next_excPc = excPc;
    next_excCcr = excCcr;
    next_memAddr = memAddr;
    next_sleepMode = sleepMode;
    next_taken = taken;
    next_inExc = inExc;
    next_copyWord = copyWord;
    memWe0 = 1'b0;
    memWe1 = 1'b0;
    memA0 = extAddr;
    memD0 = 8'h00;
    if (state == cbbse_pkg::ST_COPY) begin
      // one byte per cycle, pointers post-increment
      memWe0 = 1'b1;
      memA0 = dstPtr[MEM_AW-1:0];
      memD0 = mem[srcPtr[MEM_AW-1:0]];
      next_srcPtr = srcPtr + 16'h0001;
      next_dstPtr = dstPtr + 16'h0001;
      next_count = cntDec;
      // hand back at once when the count runs out
      if (cntSel == 16'h0001) begin
        next_state = cbbse_pkg::ST_IDLE;
        next_pc = pc + `CBBSE_UNIT_STEP;
      end
    end else if (doInstr) begin
      unique case (ins.op)
        cbbse_pkg::OP_NOP: next_pc = seqPc;
        cbbse_pkg::OP_BIT: begin
          next_pc = seqPc;
          unique case (ins.op2)
            `CBBSE_BIT_XOR: next_ccr[`CBBSE_CCR_C] = carry ^ bitVal;
            `CBBSE_BIT_IXOR: next_ccr[`CBBSE_CCR_C] = carry ^ !bitVal;
            `CBBSE_BIT_LD: next_ccr[`CBBSE_CCR_C] = bitVal;
            `CBBSE_BIT_ILD: next_ccr[`CBBSE_CCR_C] = !bitVal;
            // carry or its inverse into the bit
            `CBBSE_BIT_ST, `CBBSE_BIT_IST: begin
              if (bitMem) begin
                memWe0 = 1'b1;
                memD0 = storedByte;
              end else begin
                next_opnd = storedByte;
              end
            end
            default: next_pc = seqPc;
          endcase
        end
        cbbse_pkg::OP_BCC: begin
          next_taken = condOk;
          next_pc = condOk ? bccTarget : seqPc;
        end
        cbbse_pkg::OP_JMP: next_pc = ins.ext;
        cbbse_pkg::OP_BSR: begin
          // return address saved in the same cycle as the transfer
          next_retAddr = pc + `CBBSE_EXT_STEP;
          next_pc = pc + `CBBSE_EXT_STEP + ins.ext;
        end
        cbbse_pkg::OP_JSR: begin
          next_retAddr = pc + `CBBSE_EXT_STEP;
          next_pc = ins.ext;
        end
        cbbse_pkg::OP_RTS: next_pc = retAddr;
        cbbse_pkg::OP_TRAP: begin
          // save context, enter the handler of the 2-bit vector
          next_excPc = pc + `CBBSE_UNIT_STEP;
          next_excCcr = condition_register;
          next_inExc = 1'b1;
          next_pc = `CBBSE_TRAP_BASE + {12'h000, ins.imm8[1:0], 2'b00};
        end
        cbbse_pkg::OP_RTE: begin
          next_pc = excPc;
          next_ccr = excCcr;
          next_inExc = 1'b0;
        end
        cbbse_pkg::OP_SLEEP: begin
          // stop sequencing, pc left on the next unit
          next_sleepMode = 1'b1;
          next_pc = seqPc;
        end
        cbbse_pkg::OP_LDC: begin
          // byte or upper byte of the memory word
          next_pc = seqPc;
          if (ctlSel) next_exr = ldcSrc;
          else next_ccr = ldcSrc;
        end
        cbbse_pkg::OP_STC: begin
          // upper byte carries the value, lower byte zero
          next_pc = seqPc;
          if (ins.op2[1]) begin
            memWe0 = 1'b1;
            memWe1 = 1'b1;
            memD0 = ctlReg;
          end else begin
            next_opnd = ctlReg;
          end
        end
        // immediate logic written back to the chosen register
        cbbse_pkg::OP_CONTROL_AND_IMM, cbbse_pkg::OP_ORC, cbbse_pkg::OP_CONTROL_XOR_IMM: begin
          next_pc = seqPc;
          if (ctlSel) begin
            next_exr = (ins.op == cbbse_pkg::OP_CONTROL_AND_IMM) ? extended_register & ins.imm8 :
                       (ins.op == cbbse_pkg::OP_ORC) ? extended_register | ins.imm8 : extended_register ^ ins.imm8;
          end else begin
            next_ccr = (ins.op == cbbse_pkg::OP_CONTROL_AND_IMM) ? condition_register & ins.imm8 :
                       (ins.op == cbbse_pkg::OP_ORC) ? condition_register | ins.imm8 : condition_register ^ ins.imm8;
          end
        end
        cbbse_pkg::OP_COPY: begin
          next_copyWord = ins.op2[0];
          if (cntIns == 16'h0000) next_pc = seqPc;
          else next_state = cbbse_pkg::ST_COPY;
        end
      endcase
    end else if (wrAcc) begin
      // plain register writes; unmapped offsets are dropped
      unique case (avs_address)
        `CBBSE_OFF_PC: next_pc = wrWord[15:0];
        `CBBSE_OFF_CTRL: begin
          next_ccr = wrWord[7:0];
          next_exr = wrWord[15:8];
        end
        `CBBSE_OFF_OPND: next_opnd = wrWord[7:0];
        `CBBSE_OFF_SRC: next_srcPtr = wrWord[15:0];
        `CBBSE_OFF_DST: next_dstPtr = wrWord[15:0];
        `CBBSE_OFF_COUNT: next_count = wrWord[15:0];
        `CBBSE_OFF_STATUS: if (avs_writedata[`CBBSE_ST_SLEEP]) next_sleepMode = 1'b0;
        `CBBSE_OFF_MADDR: next_memAddr = wrWord[15:0];
        `CBBSE_OFF_MDATA: begin
          memWe0 = avs_byteenable[0];
          memA0 = memAddr[MEM_AW-1:0];
          memD0 = avs_writedata[7:0];
        end
        `CBBSE_OFF_RET: next_retAddr = wrWord[15:0];
        default: next_taken = taken;
      endcase
    end
  end

  // ====================================================================
  // bus answer: one wait cycle, none taken while a copy runs
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write) &&
                           (state == cbbse_pkg::ST_IDLE));
      avs_readdata <= curWord;
    end
  end

  // register update
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= cbbse_pkg::ST_IDLE;
      pc <= `CBBSE_RST_PC;
      condition_register <= `CBBSE_RST_CCR;
      extended_register <= `CBBSE_RST_EXR;
      {opnd, srcPtr, dstPtr, count, retAddr} <= 72'h00_0000_0000_0000_0000;
      {excPc, excCcr, memAddr} <= 40'h00_0000_0000;
      {sleepMode, taken, inExc, copyWord, powerDown} <= 5'h00;
    end else begin
      state <= next_state;
      pc <= next_pc;
      condition_register <= next_ccr;
      extended_register <= next_exr;
      {opnd, srcPtr, dstPtr, count, retAddr} <=
        {next_opnd, next_srcPtr, next_dstPtr, next_count, next_retAddr};
      {excPc, excCcr, memAddr} <= {next_excPc, next_excCcr, next_memAddr};
      {sleepMode, taken, inExc, copyWord} <= {next_sleepMode, next_taken, next_inExc,
                                              next_copyWord};
      powerDown <= next_sleepMode;
    end
  end

  // data memory: array has no reset, software loads it
  always_ff @(posedge clk) begin
    if (memWe0) mem[memA0] <= memD0;
    if (memWe1) mem[extAddr1] <= 8'h00;
  end

  // ====================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire isBit = doInstr && (ins.op == cbbse_pkg::OP_BIT) && (state == cbbse_pkg::ST_IDLE);
  wire isOp = doInstr && (state == cbbse_pkg::ST_IDLE);

  property p_xor_carry;
    isBit && ins.op2 == `CBBSE_BIT_XOR |=> condition_register[0] == ($past(carry) ^ $past(bitVal));
  endproperty
  a_xor_carry: assert property (p_xor_carry) else $error("xor carry wrong");
  property p_ixor_carry;
    isBit && ins.op2 == `CBBSE_BIT_IXOR |=> condition_register[0] == ($past(carry) ^ !$past(bitVal));
  endproperty
  a_ixor_carry: assert property (p_ixor_carry) else $error("inverted xor carry wrong");
  property p_load_carry;
    isBit && ins.op2 == `CBBSE_BIT_LD && !bitMem |=>
      condition_register[0] == $past(bitVal) && opnd == $past(opnd);
  endproperty
  a_load_carry: assert property (p_load_carry) else $error("bit load wrong");
  property p_iload_carry;
    isBit && ins.op2 == `CBBSE_BIT_ILD |=> condition_register[0] == !$past(bitVal);
  endproperty
  a_iload_carry: assert property (p_iload_carry) else $error("inverted bit load wrong");
  property p_store_bit;
    isBit && ins.op2 == `CBBSE_BIT_ST && !bitMem |=> opnd[$past(bitNo)] == $past(carry);
  endproperty
  a_store_bit: assert property (p_store_bit) else $error("bit store wrong");
  property p_istore_bit;
    isBit && ins.op2 == `CBBSE_BIT_IST && !bitMem |=> opnd[$past(bitNo)] == !$past(carry);
  endproperty
  a_istore_bit: assert property (p_istore_bit) else $error("inverted bit store wrong");
  property p_branch;
    isOp && ins.op == cbbse_pkg::OP_BCC |=>
      pc == ($past(condOk) ? $past(bccTarget) : $past(pc) + 16'h0002);
  endproperty
  a_branch: assert property (p_branch) else $error("branch target wrong");
  property p_signed_ge;
    isOp && ins.op == cbbse_pkg::OP_BCC && ins.op2 == 4'hC |=>
      taken == !($past(condition_register[3]) ^ $past(condition_register[1]));
  endproperty
  a_signed_ge: assert property (p_signed_ge) else $error("signed condition wrong");
  sequence s_call;
    isOp && (ins.op == cbbse_pkg::OP_JSR || ins.op == cbbse_pkg::OP_BSR);
  endsequence
  property p_call_return;
    s_call |=> retAddr == $past(pc) + 16'h0004;
  endproperty
  a_call_return: assert property (p_call_return) else $error("return address lost");
  property p_return;
    isOp && ins.op == cbbse_pkg::OP_RTS |=> pc == $past(retAddr);
  endproperty
  a_return: assert property (p_return) else $error("return went astray");
  property p_nop;
    isOp && ins.op == cbbse_pkg::OP_NOP |=> pc == $past(pc) + 16'h0002 && condition_register == $past(condition_register);
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation changed state");
  property p_sleep;
    isOp && ins.op == cbbse_pkg::OP_SLEEP |=> sleepMode ##1 powerDown;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
  sequence s_copy_last;
    state == cbbse_pkg::ST_COPY && cntSel == 16'h0001;
  endsequence
  property p_copy_end;
    s_copy_last |=> state == cbbse_pkg::ST_IDLE && pc == $past(pc) + 16'h0002;
  endproperty
  a_copy_end: assert property (p_copy_end) else $error("copy did not end cleanly");
  property p_copy_zero;
    isOp && ins.op == cbbse_pkg::OP_COPY && cntIns == 16'h0000 |=>
      state == cbbse_pkg::ST_IDLE && count == $past(count);
  endproperty
  a_copy_zero: assert property (p_copy_zero) else $error("zero count copy moved data");
endmodule

// [verification/cbbse_avm_master.sv]
// avalon-mm master model standing in for software on the register bus
`timescale 1ns/1ps
module cbbse_avm_master (
  input wire logic clk,
  output logic [5:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writeData,
  output logic [3:0] byteEnable,
  input wire logic waitRequest,
  output logic hung
);
  // ====================================================================
  // idle bus at time zero
  initial begin
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writeData = 32'h0000_0000;
    byteEnable = 4'h0;
    hung = 1'b0;
  end

  // one bus cycle; entered right after a rising edge, the request stands
  // until waitrequest is sampled low, and an idle edge follows so that a
  // back-to-back call never drives a strobe twice in one time step
  task automatic xfer(input logic isWrite, input logic [5:0] a, input logic [31:0] d);
    int n;
    address <= a;
    read <= ~isWrite;
    write <= isWrite;
    writeData <= d;
    byteEnable <= 4'hf;
    n = 0;
    @(posedge clk);
    while (waitRequest !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) hung <= 1'b1;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// [verification/cbbse_exec_tb.sv]
// self-checking bench of the bit, branch, control and block copy unit
`timescale 1ns/1ps
`include "cbbse_params.svh"
module cbbse_exec_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wData;
  logic [3:0] be;
  logic [31:0] rData;
  logic waitReq;
  logic powerDown;
  logic [31:0] expQ[$];
  string nameQ[$];
  int failures = 0;
  int cmpCount = 0;
  logic [15:0] pc = 16'h0000;
  logic [7:0] cr[2] = '{8'h80, 8'h07};
  logic [7:0] o, v, b, f;
  logic [15:0] t, ret;
  logic tk = 1'b0;
  int n;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  cbbse_exec #(.MEM_AW(8)) cbbse_exec_inst (.clk(clk), .rst(rst), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wData), .avs_byteenable(be),
    .avs_readdata(rData), .avs_waitrequest(waitReq), .powerDown(powerDown));
  cbbse_avm_master cbbse_avm_master_inst (.clk(clk), .address(addr), .read(rd), .write(wr),
    .writeData(wData), .byteEnable(be), .waitRequest(waitReq), .hung());

  // ====================================================================
  // helpers
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmpCount++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic put(input logic [5:0] a, input logic [31:0] d);
    cbbse_avm_master_inst.xfer(1'b1, a, d);
  endtask
  // the note is queued before the read goes out
  task automatic get(input logic [5:0] a, input logic [31:0] e, input string nm);
    expQ.push_back(e);
    nameQ.push_back(nm);
    cbbse_avm_master_inst.xfer(1'b0, a, 32'h0000_0000);
  endtask
  task automatic run(input logic [31:0] i, input logic [15:0] step);
    put(`CBBSE_OFF_INSTR, i);
    pc = pc + step;
  endtask
  task automatic control_load(input logic s, input logic [7:0] d);
    run({16'h0000, 4'ha, 3'b000, s, d}, 16'h0002);
    cr[s] = d;
  endtask
  task automatic memw(input logic [7:0] a, input logic [7:0] d);
    put(`CBBSE_OFF_MADDR, {24'h00_0000, a});
    put(`CBBSE_OFF_MDATA, {24'h00_0000, d});
  endtask
  task automatic memr(input logic [7:0] a, input logic [7:0] e);
    put(`CBBSE_OFF_MADDR, {24'h00_0000, a});
    get(`CBBSE_OFF_MDATA, {24'h00_0000, e}, "memory");
  endtask
  function automatic logic [31:0] ctl();
    return {16'h0000, cr[1], cr[0]};
  endfunction
  // odd codes take the term, even codes its inverse; term 0 is never
  function automatic logic taken(input logic [3:0] c, input logic [3:0] f);
    logic [7:0] m;
    m = {f[2] | (f[3] ^ f[1]), f[3] ^ f[1], f[3], f[1], f[2], f[0], f[0] | f[2], 1'b0};
    return c[0] ? m[c[3:1]] : ~m[c[3:1]];
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ====================================================================
  // accepted reads retire the oldest note; a hung bus ends the run
  always @(posedge clk) begin
    if (rd === 1'b1 && waitReq === 1'b0 && expQ.size() > 0) begin
      check(nameQ.pop_front(), expQ.pop_front(), rData);
    end
    if (cbbse_avm_master_inst.hung === 1'b1) begin
      failures++;
      wrap_up();
    end
  end

  // ====================================================================
  // main sequence
  initial begin
    void'($urandom(33229));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    get(`CBBSE_OFF_PC, 32'h0000_0000, "reset pc");
    get(`CBBSE_OFF_CTRL, ctl(), "reset ctrl");
    get(`CBBSE_OFF_STATUS, 32'h0000_0000, "reset status");
    get(6'h30, 32'h0000_0000, "unmapped");
    $display("test reset done");
    // bit ops on a register operand, every sub-code
    for (int k = 0; k < 6; k++) begin
      repeat (3) begin
        o = 8'($urandom);
        b = 8'($urandom % 8);
        v = {7'h40, 1'($urandom)};
        put(`CBBSE_OFF_OPND, {24'h00_0000, o});
        control_load(1'b0, v);
        run({16'h0000, 4'h1, 4'(k), 5'h00, b[2:0]}, 16'h0002);
        case (k)
          0: cr[0][0] = v[0] ^ o[b];
          1: cr[0][0] = v[0] ^ ~o[b];
          2: cr[0][0] = o[b];
          3: cr[0][0] = ~o[b];
          4: o[b] = v[0];
          default: o[b] = ~v[0];
        endcase
        get(`CBBSE_OFF_CTRL, ctl(), "carry");
        get(`CBBSE_OFF_OPND, {24'h00_0000, o}, "operand");
      end
    end
    memw(8'h60, o);
    run({16'h0060, 4'h1, 4'h5, 5'h01, b[2:0]}, 16'h0004);
    o[b] = ~cr[0][0];
    memr(8'h60, o);
    run({16'h0060, 4'h1, 4'h2, 5'h01, b[2:0]}, 16'h0004);
    cr[0][0] = o[b];
    get(`CBBSE_OFF_CTRL, ctl(), "mem carry");
    get(`CBBSE_OFF_PC, {16'h0000, pc}, "pc");
    $display("test bit ops done");
    // every branch condition against random flags
    for (int c = 0; c < 16; c++) begin
      repeat (3) begin
        f = 8'($urandom % 16);
        b = 8'($urandom) & 8'hfe;
        control_load(1'b0, f);
        run({16'h0000, 4'h2, 4'(c), b}, 16'h0002);
        tk = taken(4'(c), f[3:0]);
        if (tk) pc = pc + {{8{b[7]}}, b};
        get(`CBBSE_OFF_PC, {16'h0000, pc}, "branch pc");
        get(`CBBSE_OFF_STATUS, {29'h0, tk, 2'b00}, "taken");
      end
    end
    $display("test branch done");
    // jump, relative call, return, trap and exception return
    t = 16'($urandom) & 16'hfffe;
    run({t, 4'h3, 12'h000}, 16'h0000);
    pc = t;
    get(`CBBSE_OFF_PC, {16'h0000, pc}, "jump pc");
    t = 16'($urandom) & 16'h0ffe;
    run({t, 4'h4, 12'h000}, 16'h0004);
    ret = pc;
    pc = pc + t;
    get(`CBBSE_OFF_PC, {16'h0000, pc}, "call pc");
    get(`CBBSE_OFF_RET, {16'h0000, ret}, "saved return");
    run({16'h0000, 4'h6, 12'h000}, 16'h0000);
    pc = ret;
    get(`CBBSE_OFF_PC, {16'h0000, pc}, "return pc");
    t = 16'($urandom) & 16'hfffe;
    run({t, 4'h5, 12'h000}, 16'h0004);
    ret = pc;
    get(`CBBSE_OFF_PC, {16'h0000, t}, "abs call pc");
    get(`CBBSE_OFF_RET, {16'h0000, ret}, "abs return");
    run({16'h0000, 4'h6, 12'h000}, 16'h0000);
    pc = ret;
    get(`CBBSE_OFF_PC, {16'h0000, pc}, "abs return pc");
    ret = pc + 16'h0002;
    run({16'h0000, 4'h7, 12'h003}, 16'h0000);
    pc = 16'h001c;
    get(`CBBSE_OFF_PC, {16'h0000, pc}, "trap pc");
    get(`CBBSE_OFF_STATUS, {28'h0, 1'b1, tk, 2'b00}, "in exception");
    run({16'h0000, 4'h8, 12'h000}, 16'h0000);
    pc = ret;
    get(`CBBSE_OFF_PC, {16'h0000, pc}, "exc return pc");
    $display("test flow done");
    // control register load, store and immediate logic, both registers
    for (int s = 0; s < 2; s++) begin
      control_load(1'(s), 8'($urandom));
      for (int op = 12; op < 15; op++) begin
        v = 8'($urandom);
        run({16'h0000, 4'(op), 3'b000, 1'(s), v}, 16'h0002);
        cr[s] = (op == 12) ? cr[s] & v : (op == 13) ? cr[s] | v : cr[s] ^ v;
        get(`CBBSE_OFF_CTRL, ctl(), "ctrl imm");
      end
      o = 8'($urandom);
      put(`CBBSE_OFF_OPND, {24'h00_0000, o});
      run({16'h0000, 4'ha, 3'b001, 1'(s), 8'h00}, 16'h0002);
      cr[s] = o;
      get(`CBBSE_OFF_CTRL, ctl(), "ctrl from opnd");
      v = 8'($urandom);
      memw(8'h40, v);
      memw(8'h41, ~v);
      run({16'h0040, 4'ha, 3'b010, 1'(s), 8'h00}, 16'h0004);
      cr[s] = v;
      get(`CBBSE_OFF_CTRL, ctl(), "ctrl from mem");
      run({16'h0000, 4'hb, 3'b000, 1'(s), 8'h00}, 16'h0002);
      get(`CBBSE_OFF_OPND, {24'h00_0000, cr[s]}, "store opnd");
      memw(8'h51, 8'h5a);
      run({16'h0050, 4'hb, 3'b001, 1'(s), 8'h00}, 16'h0004);
      memr(8'h50, cr[s]);
      memr(8'h51, 8'h00);
    end
    get(`CBBSE_OFF_PC, {16'h0000, pc}, "ctrl pc");
    run(32'h0000_0000, 16'h0002);
    get(`CBBSE_OFF_PC, {16'h0000, pc}, "nop pc");
    get(`CBBSE_OFF_CTRL, ctl(), "nop ctrl");
    get(`CBBSE_OFF_OPND, {24'h00_0000, cr[1]}, "nop opnd");
    $display("test control done");
    // byte-count copy keeps the count's upper byte; a zero count does nothing
    for (int k = 0; k < 4; k++) memw(8'h80 + 8'(k), 8'h3c ^ 8'(k * 29));
    put(`CBBSE_OFF_SRC, 32'h0000_0080);
    put(`CBBSE_OFF_DST, 32'h0000_00a0);
    put(`CBBSE_OFF_COUNT, 32'h0000_0304);
    run({16'h0000, 4'hf, 12'h000}, 16'h0002);
    get(`CBBSE_OFF_PC, {16'h0000, pc}, "copy pc");
    get(`CBBSE_OFF_SRC, 32'h0000_0084, "copy src");
    get(`CBBSE_OFF_DST, 32'h0000_00a4, "copy dst");
    get(`CBBSE_OFF_COUNT, 32'h0000_0300, "copy count");
    for (int k = 0; k < 4; k++) memr(8'ha0 + 8'(k), 8'h3c ^ 8'(k * 29));
    put(`CBBSE_OFF_COUNT, 32'h0000_0000);
    run({16'h0000, 4'hf, 12'h100}, 16'h0002);
    get(`CBBSE_OFF_SRC, 32'h0000_0084, "zero copy src");
    get(`CBBSE_OFF_PC, {16'h0000, pc}, "zero copy pc");
    $display("test copy done");
    // sleep, ignored instruction while asleep, wake through status
    run({16'h0000, 4'h9, 12'h000}, 16'h0002);
    n = 0;
    while (powerDown !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    check("power down", 32'h0000_0001, {31'h0, powerDown});
    if (n >= 20) wrap_up();
    get(`CBBSE_OFF_STATUS, {29'h0, tk, 2'b10}, "sleep status");
    put(`CBBSE_OFF_INSTR, {16'h0000, 4'ha, 4'h0, ~cr[0]});
    get(`CBBSE_OFF_CTRL, ctl(), "asleep ctrl");
    get(`CBBSE_OFF_PC, {16'h0000, pc}, "asleep pc");
    put(`CBBSE_OFF_STATUS, 32'h0000_0002);
    n = 0;
    while (powerDown !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    check("wake", 32'h0000_0000, {31'h0, powerDown});
    if (n >= 20) wrap_up();
    $display("test sleep done");
    wrap_up();
  end
endmodule
